// *** design/pixel_gain_offset_shift.sv ***
// How it works
// RULE1: 8-bit depth: each gain code 0..500
// RULE2: 8-bit depth: global plus tap gain <=500
// RULE3: 12-bit depth: each gain code 0..400
// RULE4: 12-bit depth: global plus tap gain <=400
// RULE5: Half gain is global plus tap, 0.0359dB
// RULE6: Gain write lands in selected setting
// RULE7: Automatic gain changes only global gain
// RULE8: Black level codes accepted within 0..1023
// RULE9: Half offset is global plus tap black
// RULE10: Global plus tap black level <=1023
// RULE11: 8-bit: 64 black codes per count
// RULE12: 12-bit: 4 black codes per count
// RULE13: Black level write lands in selected setting
// RULE14: Shift 1..4 multiplies output by 2..16
// RULE15: 12-bit: bits 11-n..0 then n zeros
// RULE16: 8-bit unshifted: converter bits eleven to four
// RULE17: 8-bit shift n: bits 11-n..4-n
// RULE18: Lost top bit set saturates whole pixel
// RULE19: Out-of-limit writes rejected, old value kept
// RULE20: Tap of arrival picks the sensor half
`default_nettype none
`include "pgos_defines.svh"

module pixel_gain_offset_shift (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // Format and digital shift
  input wire logic i_depth_12,
  input wire logic [2:0] i_shift,
  // Manual gain write
  input wire pgos_pkg::target_type i_gain_target_choice,
  input wire logic i_gain_code_wr,
  input wire logic [9:0] i_gain_code_value,
  // Automatic gain update
  input wire logic i_auto_gain_wr,
  input wire logic [9:0] i_auto_gain_value,
  // Black level write
  input wire pgos_pkg::target_type i_offset_target_choice,
  input wire logic i_offset_code_wr,
  input wire logic [10:0] i_offset_code_value,
  // Converter pixel stream
  input wire pgos_pkg::pix_type i_pix,
  // Conditioned pixel stream
  output pgos_pkg::pix_type o_pix,
  // Current settings
  output logic [9:0] o_gain_all,
  output logic [9:0] o_gain_tap1,
  output logic [9:0] o_gain_tap2,
  output logic [9:0] o_offset_all,
  output logic [9:0] o_offset_tap1,
  output logic [9:0] o_offset_tap2,
  // Write refusals
  output logic o_gain_reject,
  output logic o_offset_reject
);

  // ===================================================================
  // Helpers

  // Range and pair-sum check for a write to the chosen setting
  function automatic logic within_limits(
    input pgos_pkg::target_type sel,
    input logic [10:0] val,
    input logic [9:0] all,
    input logic [9:0] tap1,
    input logic [9:0] tap2,
    input logic [10:0] lim
  );
    logic [11:0] v;
    logic ok;
    v = {1'b0, val};
    unique case (sel)
      pgos_pkg::TGT_ALL: begin
        ok = (v <= {1'b0, lim});
        ok = ok && (v + {2'h0, tap1} <= {1'b0, lim});
        ok = ok && (v + {2'h0, tap2} <= {1'b0, lim});
      end
      pgos_pkg::TGT_TAP1: begin
        ok = (v <= {1'b0, lim}) && ({2'h0, all} + v <= {1'b0, lim});
      end
      pgos_pkg::TGT_TAP2: begin
        ok = (v <= {1'b0, lim}) && ({2'h0, all} + v <= {1'b0, lim});
      end
      default: begin
        ok = 1'b0;
      end
    endcase
    return ok;
  endfunction : within_limits

  // Linear factor in Q8 for a total gain code of 0.0359 dB steps
  function automatic logic [11:0] gain_factor(input logic [9:0] code);
    int unsigned c;
    int unsigned e;
    int unsigned rem;
    int unsigned f;
    int unsigned mant;
    c = 32'(code);
    e = c / `GAIN_OCTAVE_STEPS;
    rem = c - e * `GAIN_OCTAVE_STEPS;
    f = (rem * `GAIN_FRAC_RECIP) >> 7;
    mant = `MANT_ONE_Q8 + ((f * `MANT_LIN_Q8) >> 8) + ((f * f * `MANT_SQ_Q8) >> 16);
    return 12'(mant << e);
  endfunction : gain_factor

  // ===================================================================
  // Settings and limits
  logic [9:0] gain_all_r;
  logic [9:0] gain_tap1_r;
  logic [9:0] gain_tap2_r;
  logic [9:0] offset_all_r;
  logic [9:0] offset_tap1_r;
  logic [9:0] offset_tap2_r;
  logic gain_reject_r;
  logic offset_reject_r;
  logic [10:0] gain_lim;
  logic gain_wr_ok;
  logic auto_wr_ok;
  logic offset_wr_ok;

  // Depth picks the gain ceiling
  assign gain_lim = i_depth_12 ? `GAIN_MAX_12BIT : `GAIN_MAX_8BIT; // [RULE1] [RULE3]

  // Manual gain write against the ceiling of the current depth
  always_comb begin
    gain_wr_ok = within_limits(i_gain_target_choice, {1'b0, i_gain_code_value}, gain_all_r,
                               gain_tap1_r, gain_tap2_r, gain_lim); // [RULE1] [RULE2] [RULE3] [RULE4]
  end

  // Automatic update only ever targets the global code
  always_comb begin
    auto_wr_ok = within_limits(pgos_pkg::TGT_ALL, {1'b0, i_auto_gain_value}, gain_all_r,
                               gain_tap1_r, gain_tap2_r, gain_lim); // [RULE2] [RULE4]
  end

  // Black level write against the fixed ceiling
  always_comb begin
    offset_wr_ok = within_limits(i_offset_target_choice, i_offset_code_value, offset_all_r,
                                 offset_tap1_r, offset_tap2_r, `BLACK_MAX); // [RULE8] [RULE10]
  end

  // ===================================================================
  // Gain settings; a manual write wins over an automatic one
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      gain_all_r <= `GAIN_RST;
      gain_tap1_r <= `GAIN_RST;
      gain_tap2_r <= `GAIN_RST;
    end else if (i_gain_code_wr) begin
      if (gain_wr_ok) begin // [RULE19]
        unique case (i_gain_target_choice)
          pgos_pkg::TGT_ALL: gain_all_r <= i_gain_code_value; // [RULE6]
          pgos_pkg::TGT_TAP1: gain_tap1_r <= i_gain_code_value; // [RULE6]
          pgos_pkg::TGT_TAP2: gain_tap2_r <= i_gain_code_value; // [RULE6]
          default: gain_all_r <= gain_all_r;
        endcase
      end
    end else if (i_auto_gain_wr && auto_wr_ok) begin
      gain_all_r <= i_auto_gain_value; // [RULE7]
    end
  end

  // Gain refusal pulse
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      gain_reject_r <= 1'b0;
    end else begin
      gain_reject_r <= (i_gain_code_wr && !gain_wr_ok)
                       || (!i_gain_code_wr && i_auto_gain_wr && !auto_wr_ok); // [RULE19]
    end
  end

  // ===================================================================
  // Black level settings
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      offset_all_r <= `BLACK_RST;
      offset_tap1_r <= `BLACK_RST;
      offset_tap2_r <= `BLACK_RST;
    end else if (i_offset_code_wr && offset_wr_ok) begin // [RULE19]
      unique case (i_offset_target_choice)
        pgos_pkg::TGT_ALL: offset_all_r <= i_offset_code_value[9:0]; // [RULE13]
        pgos_pkg::TGT_TAP1: offset_tap1_r <= i_offset_code_value[9:0]; // [RULE13]
        pgos_pkg::TGT_TAP2: offset_tap2_r <= i_offset_code_value[9:0]; // [RULE13]
        default: offset_all_r <= offset_all_r;
      endcase
    end
  end

  // Black level refusal pulse
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      offset_reject_r <= 1'b0;
    end else begin
      offset_reject_r <= i_offset_code_wr && !offset_wr_ok; // [RULE19]
    end
  end

  // ===================================================================
  // Stage 1: gain per half
  pgos_pkg::pix_type s1_r;
  logic [9:0] code_right;
  logic [9:0] code_left;
  logic [11:0] fac_right;
  logic [11:0] fac_left;
  logic [11:0] fac_sel;
  logic [23:0] prod;
  logic [15:0] gained;

  // Total code per half; each code is at most 500, so sums fit ten bits
  always_comb begin
    code_right = 10'(gain_all_r + gain_tap1_r); // [RULE5]
    code_left = 10'(gain_all_r + gain_tap2_r); // [RULE5]
  end

  // Linear factor per half, then the one for this pixel
  always_comb begin
    fac_right = gain_factor(code_right); // [RULE5]
    fac_left = gain_factor(code_left); // [RULE5]
    fac_sel = i_pix.left ? fac_left : fac_right; // [RULE20]
    prod = i_pix.data * fac_sel;
    gained = prod[23:8];
  end

  // Register the gained sample, clipped to the converter range
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s1_r <= '0;
    end else begin
      s1_r.valid <= i_pix.valid;
      s1_r.left <= i_pix.left; // [RULE20]
      s1_r.data <= (|gained[15:12]) ? 12'hFFF : gained[11:0];
    end
  end

  // ===================================================================
  // Stage 2: bit window and black level
  logic [11:0] win;
  logic [10:0] black_total;
  logic [10:0] black_counts;
  logic [12:0] summed;
  logic [11:0] leveled;
  pgos_pkg::pix_type out_r;

  pixel_bit_window u_window (
    .i_sample(s1_r.data),
    .i_shift(i_shift),
    .i_depth_12(i_depth_12),
    .o_window(win)
  );

  // Black total of this pixel's half
  always_comb begin
    black_total = s1_r.left ? ({1'b0, offset_all_r} + {1'b0, offset_tap2_r})
                            : ({1'b0, offset_all_r} + {1'b0, offset_tap1_r}); // [RULE9]
  end

  // Black total in output counts; partial steps are truncated
  always_comb begin
    black_counts = i_depth_12 ? (black_total / `BLACK_STEP_12BIT) // [RULE12]
                              : (black_total / `BLACK_STEP_8BIT); // [RULE11]
  end

  // Add offset and clip at full scale of the depth
  always_comb begin
    summed = {1'b0, win} + {2'h0, black_counts};
    if (i_depth_12) begin
      leveled = summed[12] ? 12'hFFF : summed[11:0];
    end else begin
      leveled = (|summed[12:8]) ? 12'h0FF : summed[11:0];
    end
  end

  // Output pixel register
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      out_r <= '0;
    end else begin
      out_r.valid <= s1_r.valid;
      out_r.left <= s1_r.left;
      out_r.data <= leveled;
    end
  end

  // ===================================================================
  // Outputs, all from flip-flops
  assign o_pix = out_r;
  assign o_gain_all = gain_all_r;
  assign o_gain_tap1 = gain_tap1_r;
  assign o_gain_tap2 = gain_tap2_r;
  assign o_offset_all = offset_all_r;
  assign o_offset_tap1 = offset_tap1_r;
  assign o_offset_tap2 = offset_tap2_r;
  assign o_gain_reject = gain_reject_r;
  assign o_offset_reject = offset_reject_r;

endmodule : pixel_gain_offset_shift

`default_nettype wire

// *** design/pgos_defines.svh ***
`ifndef PGOS_DEFINES_SVH
`define PGOS_DEFINES_SVH

// =====================================================================
// Converter and output widths
`define ADC_BITS 12
`define OUT8_BITS 8
`define SHIFT_MAX 3'h4

// =====================================================================
// Gain code limits and reset values
`define GAIN_MAX_8BIT 11'h1F4
`define GAIN_MAX_12BIT 11'h190
`define GAIN_RST 10'h000

// Gain step and one octave, both in units of 0.0001 dB
`define GAIN_STEP_DB_E4 32'h0000_0167
`define GAIN_OCTAVE_DB_E4 32'h0000_EB2E
`define GAIN_OCTAVE_STEPS ((`GAIN_OCTAVE_DB_E4 + `GAIN_STEP_DB_E4 / 32'h2) / `GAIN_STEP_DB_E4)
// Fraction of an octave in Q8, scaled by 128 to keep precision
`define GAIN_FRAC_RECIP ((32'h100 * 32'h80) / `GAIN_OCTAVE_STEPS)
// Quadratic fit of 2^f in Q8: 1 + 0.6565 f + 0.3435 f^2
`define MANT_ONE_Q8 32'h100
`define MANT_LIN_Q8 32'hA8
`define MANT_SQ_Q8 32'h58

// =====================================================================
// Black level limits, steps per output count and reset values
`define BLACK_MAX 11'h3FF
`define BLACK_RST 10'h000
`define BLACK_STEP_8BIT 11'h040
`define BLACK_STEP_12BIT 11'h004

`endif

// *** design/pgos_pkg.sv ***
`default_nettype none

package pgos_pkg;

  // ===================================================================
  // Which setting a written code lands in
  typedef enum logic [1:0] {
    TGT_ALL = 2'h0,
    TGT_TAP1 = 2'h1,
    TGT_TAP2 = 2'h2
  } target_type;

  // ===================================================================
  // One pixel on the stream; left set means second tap, left half
  typedef struct packed {
    logic valid;
    logic left;
    logic [11:0] data;
  } pix_type;

endpackage : pgos_pkg

`default_nettype wire

// *** design/pixel_bit_window.sv ***
`default_nettype none
`include "pgos_defines.svh"

module pixel_bit_window (
  // Sample and window setting
  input wire logic [11:0] i_sample,
  input wire logic [2:0] i_shift,
  input wire logic i_depth_12,
  // Selected bit group, 8-bit result in the low bits
  output logic [11:0] o_window
);

  // ===================================================================
  // Window selection
  logic [2:0] shift_eff;
  logic [11:0] top_mask;
  logic overflow;
  logic [11:0] narrow;

  // Clamp shift and find bits lost off the top
  always_comb begin
    shift_eff = (i_shift > `SHIFT_MAX) ? `SHIFT_MAX : i_shift;
    top_mask = ~(12'hFFF >> shift_eff);
    overflow = |(i_sample & top_mask); // [RULE18]
    narrow = i_sample >> (3'h4 - shift_eff);
  end

  // Saturate or pass the chosen group
  always_comb begin
    if (i_depth_12) begin
      o_window = overflow ? 12'hFFF : (i_sample << shift_eff); // [RULE15] [RULE14] [RULE18]
    end else begin
      o_window = {4'h0, overflow ? 8'hFF : narrow[7:0]}; // [RULE16] [RULE17] [RULE18]
    end
  end

endmodule : pixel_bit_window

`default_nettype wire

// *** verif/pgos_converter_model.sv ***
`default_nettype none

module pgos_converter_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Sample request from the bench
  input wire logic i_send,
  input wire logic i_left,
  input wire logic [11:0] i_data,
  // Converter stream
  output pgos_pkg::pix_type o_pix
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==================================================================
  // One 12-bit sample per request, scrambled and invalid between them
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pix <= '0;
    end else if (i_send) begin
      o_pix <= {1'b1, i_left, i_data};
    end else begin
      o_pix <= {1'b0, ~o_pix.left, ~o_pix.data};
    end
  end
endmodule : pgos_converter_model

`default_nettype wire

// *** verif/pgos_sva.sv ***
`default_nettype none

module pgos_sva (
  // Clock, reset, format
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_depth_12,
  // Writes
  input wire pgos_pkg::target_type i_gain_target_choice,
  input wire logic i_gain_code_wr,
  input wire logic [9:0] i_gain_code_value,
  input wire logic i_auto_gain_wr,
  input wire pgos_pkg::target_type i_offset_target_choice,
  input wire logic i_offset_code_wr,
  input wire logic [10:0] i_offset_code_value,
  // Streams
  input wire pgos_pkg::pix_type i_pix,
  input wire pgos_pkg::pix_type o_pix,
  // Settings and refusals
  input wire logic [9:0] o_gain_all,
  input wire logic [9:0] o_gain_tap1,
  input wire logic [9:0] o_gain_tap2,
  input wire logic [9:0] o_offset_all,
  input wire logic [9:0] o_offset_tap1,
  input wire logic [9:0] o_offset_tap2,
  input wire logic o_gain_reject,
  input wire logic o_offset_reject
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==================================================================
  // Global write that would push either black sum over the ceiling
  function automatic logic i_offset_code_target_all();
    return i_offset_target_choice == pgos_pkg::TGT_ALL && ({1'b0, i_offset_code_value} + {2'h0, o_offset_tap1}
      > 12'h3FF || {1'b0, i_offset_code_value} + {2'h0, o_offset_tap2} > 12'h3FF);
  endfunction : i_offset_code_target_all
  // ==================================================================
  // Limits and sums
  logic [10:0] glim;
  logic [10:0] gsum_all;
  logic [11:0] bsum_all;
  assign glim = i_depth_12 ? 11'h190 : 11'h1F4;
  assign gsum_all = {1'b0, o_gain_all} + {1'b0, i_gain_code_value};
  assign bsum_all = {2'h0, o_offset_all} + {1'h0, i_offset_code_value};
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_pix_in;
    i_pix.valid ##0 i_pix.left;
  endsequence
  // ==================================================================
  // Checks
  a_gain_tap1_store: assert property (i_gain_code_wr && i_gain_target_choice == pgos_pkg::TGT_TAP1
    && gsum_all <= glim |=> o_gain_tap1 == $past(i_gain_code_value) && !o_gain_reject) else $error("tap1 gain lost");
  a_gain_over_refused: assert property (i_gain_code_wr && {1'b0, i_gain_code_value} > glim
    |=> o_gain_reject && $stable(o_gain_all) && $stable(o_gain_tap1)) else $error("gain over limit kept");
  a_gain_sum_refused: assert property (i_gain_code_wr && i_gain_target_choice == pgos_pkg::TGT_TAP2
    && gsum_all > glim |=> o_gain_reject && $stable(o_gain_tap2)) else $error("gain sum kept");
  a_auto_taps_kept: assert property (i_auto_gain_wr && !i_gain_code_wr
    |=> $stable(o_gain_tap1) && $stable(o_gain_tap2)) else $error("auto gain moved a tap");
  a_offset_over_refused: assert property (i_offset_code_wr && i_offset_code_value > 11'h3FF
    |=> o_offset_reject && $stable(o_offset_all)) else $error("offset over limit kept");
  a_offset_sum_refused: assert property (i_offset_code_wr && i_offset_code_target_all()
    |=> o_offset_reject && $stable(o_offset_all)) else $error("offset sum kept");
  a_offset_tap2_store: assert property (i_offset_code_wr && i_offset_target_choice == pgos_pkg::TGT_TAP2
    && bsum_all <= 12'h3FF |=> o_offset_tap2 == $past(i_offset_code_value)) else $error("tap2 offset lost");
  a_pix_two_cycles: assert property (s_pix_in |-> ##2 o_pix.valid && o_pix.left) else $error("pixel late");
  a_narrow_top_zero: assert property (!$past(i_depth_12) |-> o_pix.data[11:8] == 4'h0) else $error("8-bit high");
endmodule : pgos_sva

`default_nettype wire

// *** verif/test_pixel_gain_offset_shift.sv ***
`default_nettype none

module test_pixel_gain_offset_shift;
  timeunit 1ns;
  timeprecision 1ps;
  // ==================================================================
  // Design signals and bench state
  logic i_ref_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_depth_12 = 1'b0;
  logic [2:0] i_shift = 3'h0;
  pgos_pkg::target_type i_gain_target_choice = pgos_pkg::TGT_ALL;
  pgos_pkg::target_type i_offset_target_choice = pgos_pkg::TGT_ALL;
  logic i_gain_code_wr = 1'b0;
  logic i_offset_code_wr = 1'b0;
  logic i_auto_gain_wr = 1'b0;
  logic [9:0] i_gain_code_value = 10'h000;
  logic [9:0] i_auto_gain_value = 10'h000;
  logic [10:0] i_offset_code_value = 11'h000;
  logic send = 1'b0;
  logic send_left = 1'b0;
  logic [11:0] send_data = 12'h000;
  pgos_pkg::pix_type i_pix;
  pgos_pkg::pix_type o_pix;
  logic [9:0] o_gain_all, o_gain_tap1, o_gain_tap2, o_offset_all, o_offset_tap1, o_offset_tap2;
  logic o_gain_reject, o_offset_reject;
  int mismatches = 0;
  int checks_done = 0;
  always #2.5 i_ref_clk = ~i_ref_clk;
  pixel_gain_offset_shift u_pixel_gain_offset_shift (.*);
  pgos_converter_model u_pgos_converter_model (.i_clk(i_ref_clk), .i_rst(i_sys_rst), .i_send(send),
    .i_left(send_left), .i_data(send_data), .o_pix(i_pix));
  // ==================================================================
  // Shared tasks
  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic put(input logic g, input pgos_pkg::target_type c, input logic [10:0] v, input logic rej);
    @(posedge i_ref_clk);
    i_gain_target_choice <= c;
    i_offset_target_choice <= c;
    i_gain_code_value <= v[9:0];
    i_offset_code_value <= v;
    i_gain_code_wr <= g;
    i_offset_code_wr <= !g;
    @(posedge i_ref_clk);
    i_gain_code_wr <= 1'b0;
    i_offset_code_wr <= 1'b0;
    #1;
    check("write refusal", g ? o_gain_reject : o_offset_reject, rej);
  endtask : put
  task automatic pix(input logic left, input logic [11:0] d, input logic [11:0] exp);
    @(posedge i_ref_clk);
    send <= 1'b1;
    send_left <= left;
    send_data <= d;
    @(posedge i_ref_clk);
    send <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    #1;
    check("pixel data", o_pix.data, exp);
    check("pixel half", o_pix.left, left);
  endtask : pix
  // ==================================================================
  // Scenarios
  task automatic test_gain_limits;
    logic [10:0] lim;
    for (int d = 0; d < 2; d++) begin
      lim = d ? 11'h190 : 11'h1F4;
      i_depth_12 <= d[0];
      put(1'b1, pgos_pkg::TGT_ALL, lim + 11'h001, 1'b1);
      put(1'b1, pgos_pkg::TGT_ALL, lim, 1'b0);
      put(1'b1, pgos_pkg::TGT_TAP1, 11'h001, 1'b1);
      put(1'b1, pgos_pkg::TGT_ALL, 11'h00A, 1'b0);
      put(1'b1, pgos_pkg::TGT_TAP2, lim - 11'h00A, 1'b0);
      put(1'b1, pgos_pkg::target_type'(2'h3), 11'h000, 1'b1);
      check("gain all", o_gain_all, 12'h00A);
      check("gain tap2", o_gain_tap2, lim - 11'h00A);
      put(1'b1, pgos_pkg::TGT_TAP2, 11'h000, 1'b0);
    end
  endtask : test_gain_limits
  task automatic test_auto;
    put(1'b1, pgos_pkg::TGT_TAP1, 11'h014, 1'b0);
    @(posedge i_ref_clk);
    i_auto_gain_value <= 10'h064;
    i_auto_gain_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_auto_gain_wr <= 1'b0;
    #1;
    check("auto all", o_gain_all, 12'h064);
    check("auto tap1", o_gain_tap1, 12'h014);
    put(1'b1, pgos_pkg::TGT_TAP1, 11'h000, 1'b0);
    put(1'b1, pgos_pkg::TGT_ALL, 11'h000, 1'b0);
  endtask : test_auto
  task automatic test_offset_limits;
    put(1'b0, pgos_pkg::TGT_ALL, 11'h400, 1'b1);
    put(1'b0, pgos_pkg::TGT_ALL, 11'h3FF, 1'b0);
    put(1'b0, pgos_pkg::TGT_TAP1, 11'h001, 1'b1);
    put(1'b0, pgos_pkg::TGT_ALL, 11'h000, 1'b0);
    put(1'b0, pgos_pkg::TGT_TAP2, 11'h3FF, 1'b0);
    check("offset tap2", o_offset_tap2, 12'h3FF);
    put(1'b0, pgos_pkg::TGT_TAP2, 11'h000, 1'b0);
  endtask : test_offset_limits
  task automatic test_window;
    for (int n = 0; n < 5; n++) begin
      i_shift <= n[2:0];
      i_depth_12 <= 1'b1;
      pix(1'b0, 12'h0F3, 12'h0F3 << n);
      pix(1'b1, 12'h800, n ? 12'hFFF : 12'h800);
      i_depth_12 <= 1'b0;
      pix(1'b0, 12'h0F3, (12'h0F3 << n) >> 4);
      pix(1'b1, 12'h800, n ? 12'h0FF : 12'h080);
    end
    i_shift <= 3'h0;
  endtask : test_window
  task automatic test_half_settings;
    put(1'b0, pgos_pkg::TGT_TAP1, 11'h040, 1'b0);
    pix(1'b0, 12'h100, 12'h011);
    pix(1'b1, 12'h100, 12'h010);
    i_depth_12 <= 1'b1;
    pix(1'b0, 12'h100, 12'h110);
    put(1'b1, pgos_pkg::TGT_TAP2, 11'h0A8, 1'b0);
    pix(1'b1, 12'h100, 12'h200);
    pix(1'b0, 12'h100, 12'h110);
  endtask : test_half_settings
  // ==================================================================
  // Verdict, watchdog and main sequence
  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude
  initial begin
    #50000;
    mismatches++;
    conclude();
  end
  initial begin
    repeat (5) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    #1;
    check("reset settings", {2'h0, o_gain_all | o_gain_tap2 | o_offset_all | o_offset_tap1}, 12'h000);
    test_gain_limits();
    test_auto();
    test_offset_limits();
    test_window();
    test_half_settings();
    conclude();
  end
endmodule : test_pixel_gain_offset_shift

bind pixel_gain_offset_shift pgos_sva u_pgos_sva (.*);

`default_nettype wire
